// ---- hdl/idc_idle_domain_control.v ----
// Summary of operation
// (RULE_01) domain idle configuration register at 0x0001 selects domains to idle
// (RULE_02) read-only domain status register at 0x0002 shows idled domains
// (RULE_03) peripheral idle control register at 0x9400 selects peripherals to idle
// (RULE_04) read-only peripheral status register at 0x9401 shows idled peripherals
// (RULE_05) master control register at 0x9402 idles host port and DMA separately
// (RULE_06) read-only master status register at 0x9403 shows host port and DMA state
// (RULE_07) pll control register requests pll power-down, taken on the idle command
// (RULE_08) control writes only store; settings apply on the idle command (clearing periphCtrl bits, or masterCtrl bits with bit 1 not idled, also wakes)
// (RULE_09) clock generator stops only with both clock bits set; both clear keeps it
// (RULE_10) clock bit set without extended clock bit on idle raises bus error
// (RULE_11) software sets all companion idle bits before idling the clock generator
// (RULE_12) clock bit set with any companion bit clear on idle raises bus error
// (RULE_13) idling the clock generator stops the system clock
// (RULE_14) bit 8 idles the instruction fetch port after idle; resets to 0
// (RULE_15) bit 7 idles the master transfer port after idle; resets to 0
// (RULE_16) configuration bits 15 to 10 are reserved and read as zero
// (RULE_17) bit 0 idles the processor after idle
// (RULE_18) bit 1 idles both DMA and host port after idle
// (RULE_19) bit 3 idles peripherals selected in peripheral control; clear wakes all
// (RULE_20) status bit 8 reads 1 while the instruction fetch port is disabled
// (RULE_21) idle command is a one-cycle pulse that applies settings and status
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
`include "idc_regs.vh"

module idc_idle_domain_control
(
   clk,
   rstn,
   regAddr,
   regWrData,
   regWrite,
   regRead,
   regRdData,
   idleCmd,
   busError,
   domainIdle,
   periphIdle,
   dmaIdle,
   hostPortIdle,
   sysClockStop,
   pllPowerDown
);
   input  wire        clk;
   input  wire        rstn;
   input  wire [15:0] regAddr;
   input  wire [15:0] regWrData;
   input  wire        regWrite;
   input  wire        regRead;
   output reg  [15:0] regRdData;
   input  wire        idleCmd;
   output reg         busError;
   output reg  [9:0]  domainIdle;
   output reg  [15:0] periphIdle;
   output reg         dmaIdle;
   output reg         hostPortIdle;
   output reg         sysClockStop;
   output reg         pllPowerDown;

   reg  [9:0]  domainCfg;
   reg  [15:0] periphCtrl;
   reg  [1:0]  masterCtrl;
   reg         pllCtrl;

   wire        clkBit;
   wire        clkExtBit;
   wire        companionsOk;
   wire        cfgValid;
   wire [9:0]  next_domainIdle;
   wire [15:0] next_periphIdle;
   wire        next_dmaIdle;
   wire        next_hostPortIdle;

   assign clkBit       = domainCfg[`IDC_BIT_CLKGEN];
   assign clkExtBit    = domainCfg[`IDC_BIT_CLKGEN_EXT];
   assign companionsOk = ((domainCfg & `IDC_CLKGEN_COMPANIONS) == `IDC_CLKGEN_COMPANIONS);

   // (RULE_10) clock bit check
   // (RULE_12) companion bits check
   // a mixed pair with the clock bit clear is also refused: it has no valid meaning
   assign cfgValid = clkBit ? companionsOk : ~clkExtBit;

   // (RULE_17) per-domain apply
   // (RULE_14) port bits applied
   // (RULE_15) port bits applied
   assign next_domainIdle = domainCfg;

   // (RULE_19) peripheral selection
   assign next_periphIdle = domainCfg[`IDC_BIT_PERIPH] ? periphCtrl : 16'h0000;

   // (RULE_18) master domain gate
   assign next_dmaIdle      = domainCfg[`IDC_BIT_MASTER] | masterCtrl[`IDC_BIT_DMA];
   assign next_hostPortIdle = domainCfg[`IDC_BIT_MASTER] | masterCtrl[`IDC_BIT_HOSTPORT];

   // register writes only store, nothing is idled here
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         domainCfg  <= `IDC_RESET_CFG;
         periphCtrl <= `IDC_RESET_WORD;
         masterCtrl <= 2'h0;
         pllCtrl    <= 1'b0;
      end
      else if (regWrite)
      begin
         case (regAddr)
            // (RULE_01) configuration store
            // (RULE_16) upper bits dropped
            `IDC_ADDR_DOMAIN_CFG:  domainCfg  <= regWrData[9:0];
            // (RULE_03) peripheral store
            `IDC_ADDR_PERIPH_CTRL: periphCtrl <= regWrData;
            // (RULE_05) master store
            `IDC_ADDR_MASTER_CTRL: masterCtrl <= regWrData[1:0];
            // (RULE_07) pll request store
            `IDC_ADDR_PLL_CTRL:    pllCtrl    <= regWrData[`IDC_BIT_PLL_PWRDN];
            default:               pllCtrl    <= pllCtrl;
         endcase
      end
   end

   // (RULE_08) apply on idle only
   // (RULE_21) idle pulse apply
   // master control also acts directly between idle commands, so while the master domain bit 1 is not idled, waking one
   // master module needs no idle command
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         domainIdle   <= `IDC_RESET_CFG;
         periphIdle   <= `IDC_RESET_WORD;
         dmaIdle      <= 1'b0;
         hostPortIdle <= 1'b0;
         sysClockStop <= 1'b0;
         pllPowerDown <= 1'b0;
         busError     <= 1'b0;
      end
      else
      begin
         busError <= 1'b0;
         if (idleCmd)
         begin
            if (cfgValid)
            begin
               domainIdle   <= next_domainIdle;
               periphIdle   <= next_periphIdle;
               dmaIdle      <= next_dmaIdle;
               hostPortIdle <= next_hostPortIdle;
               // (RULE_09) both clock bits set
               // (RULE_13) system clock stop
               sysClockStop <= clkBit & clkExtBit;
               // (RULE_07) pll powered down on idle
               pllPowerDown <= pllCtrl;
            end
            else
            begin
               // (RULE_10) bus error pulse
               // (RULE_12) bus error pulse
               busError <= 1'b1;
            end
         end
         else
         begin
            // peripherals may wake individually once the domain bit idled them
            periphIdle   <= periphIdle & periphCtrl;
            dmaIdle      <= dmaIdle & (domainIdle[`IDC_BIT_MASTER] | masterCtrl[`IDC_BIT_DMA]);
            hostPortIdle <= hostPortIdle
                            & (domainIdle[`IDC_BIT_MASTER] | masterCtrl[`IDC_BIT_HOSTPORT]);
         end
      end
   end

   // read data stands one cycle after the read strobe
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         regRdData <= `IDC_RESET_WORD;
      else if (regRead)
      begin
         case (regAddr)
            // (RULE_16) reserved read zero
            `IDC_ADDR_DOMAIN_CFG:  regRdData <= {6'h00, domainCfg};
            // (RULE_02) domain status
            // (RULE_20) port status bit
            `IDC_ADDR_DOMAIN_STAT: regRdData <= {6'h00, domainIdle};
            `IDC_ADDR_PERIPH_CTRL: regRdData <= periphCtrl;
            // (RULE_04) peripheral status
            `IDC_ADDR_PERIPH_STAT: regRdData <= periphIdle;
            `IDC_ADDR_MASTER_CTRL: regRdData <= {14'h0000, masterCtrl};
            // (RULE_06) master status
            `IDC_ADDR_MASTER_STAT: regRdData <= {14'h0000, hostPortIdle, dmaIdle};
            `IDC_ADDR_PLL_CTRL:    regRdData <= {14'h0000, pllPowerDown, pllCtrl};
            default:               regRdData <= `IDC_RESET_WORD;
         endcase
      end
      else
         regRdData <= `IDC_RESET_WORD;
   end

endmodule // idc_idle_domain_control

// ---- hdl/idc_regs.vh ----
`ifndef IDC_REGS_VH
`define IDC_REGS_VH

// register offsets (word addresses on the plain register port)
`define IDC_ADDR_DOMAIN_CFG    16'h0001
`define IDC_ADDR_DOMAIN_STAT   16'h0002
`define IDC_ADDR_PERIPH_CTRL   16'h9400
`define IDC_ADDR_PERIPH_STAT   16'h9401
`define IDC_ADDR_MASTER_CTRL   16'h9402
`define IDC_ADDR_MASTER_STAT   16'h9403
`define IDC_ADDR_PLL_CTRL      16'h9404

// domain configuration bit positions
`define IDC_BIT_CPU            0
`define IDC_BIT_MASTER         1
`define IDC_BIT_ICACHE         2
`define IDC_BIT_PERIPH         3
`define IDC_BIT_CLKGEN         4
`define IDC_BIT_EMIF           5
`define IDC_BIT_IOPORT         6
`define IDC_BIT_MASTER_TRANSFER_PORT          7
`define IDC_BIT_INSTRUCTION_FETCH_PORT          8
`define IDC_BIT_CLKGEN_EXT     9
`define IDC_CFG_WIDTH          10

// master control bit positions
`define IDC_BIT_DMA            0
`define IDC_BIT_HOSTPORT       1

// pll control bit positions
`define IDC_BIT_PLL_PWRDN      0

// companion bits that must accompany the clock generator idle bit
`define IDC_CLKGEN_COMPANIONS  10'h3e7

// reset values
`define IDC_RESET_CFG          10'h000
`define IDC_RESET_WORD         16'h0000

`endif

// ---- sim/idc_idle_domain_control_assertions.sv ----
`timescale 1ns/10ps
module idc_checker
(
   input wire        clk,
   input wire        rstn,
   input wire [15:0] regAddr,
   input wire [15:0] regWrData,
   input wire        regWrite,
   input wire        regRead,
   input wire [15:0] regRdData,
   input wire        idleCmd,
   input wire        busError,
   input wire [9:0]  domainIdle,
   input wire [15:0] periphIdle,
   input wire        dmaIdle,
   input wire        hostPortIdle,
   input wire        sysClockStop,
   input wire        pllPowerDown
);
   // shadow of the stored configuration, so checks need no hierarchical peeks
   logic [9:0] cfg;
   wire        bad = cfg[4] ? ((cfg & 10'h3e7) != 10'h3e7) : cfg[9];
   always_ff @(posedge clk or negedge rstn)
      if (!rstn) cfg <= 10'h000;
      else if (regWrite && regAddr == 16'h0001) cfg <= regWrData[9:0];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence goodIdle; idleCmd && !bad; endsequence
   sequence badIdle; idleCmd && bad; endsequence
   sequence perOff; idleCmd && !bad && !cfg[3]; endsequence
   rd_idle_a: assert property (!$past(regRead) |-> regRdData == 16'h0000)
      else $error("read data not zero outside read cycle");
   cfg_read_a: assert property
      ($past(regRead && regAddr == 16'h0001) |-> regRdData == {6'h00, cfg})
      else $error("config readback wrong");
   stat_read_a: assert property
      ($past(regRead && regAddr == 16'h0002) |-> regRdData == {6'h00, $past(domainIdle)})
      else $error("status readback wrong");
   idle_hold_a: assert property
      (!idleCmd |=> $stable(domainIdle) && $stable(sysClockStop))
      else $error("domain state changed without idle");
   idle_apply_a: assert property (goodIdle |=> domainIdle == $past(cfg) && !busError)
      else $error("valid idle not applied");
   idle_refuse_a: assert property (badIdle |=> busError && $stable(domainIdle))
      else $error("invalid idle not refused");
   err_cause_a: assert property (busError |-> $past(idleCmd))
      else $error("bus error without idle");
   clk_stop_a: assert property (sysClockStop == (domainIdle[4] && domainIdle[9]))
      else $error("clock stop mismatch");
   master_rise_a: assert property
      ($rose(dmaIdle) || $rose(hostPortIdle) |-> $past(idleCmd))
      else $error("master idled without idle");
   periph_off_a: assert property (perOff |=> periphIdle == 16'h0000)
      else $error("peripherals not woken");
endmodule // idc_checker
bind idc_idle_domain_control idc_checker chk (.clk(clk), .rstn(rstn), .regAddr(regAddr),
   .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
   .idleCmd(idleCmd), .busError(busError), .domainIdle(domainIdle), .periphIdle(periphIdle),
   .dmaIdle(dmaIdle), .hostPortIdle(hostPortIdle), .sysClockStop(sysClockStop),
   .pllPowerDown(pllPowerDown));

// ---- sim/test_idle_domain_control.sv ----
`timescale 1ns/10ps
module test_idle_domain_control;
   logic        clk = 0;
   logic        rstn = 0;
   logic [15:0] regAddr = 16'h0000;
   logic [15:0] regWrData = 16'h0000;
   logic        regWrite = 0;
   logic        regRead = 0;
   logic        idleCmd = 0;
   wire  [15:0] regRdData, periphIdle;
   wire  [9:0]  domainIdle;
   wire         busError, dmaIdle, hostPortIdle, sysClockStop, pllPowerDown;
   wire  [4:0]  flags = {busError, sysClockStop, pllPowerDown, dmaIdle, hostPortIdle};
   int          n_errors = 0;
   int          cmp_count = 0;
   logic [9:0]  badCfg [4] = '{10'h010, 10'h200, 10'h3fe, 10'h37f};
   // 0x0010 is unmapped, 0x9404 is the pll request register
   logic [15:0] regs [8] = '{16'h0001, 16'h0002, 16'h9400, 16'h9401, 16'h9402, 16'h9403,
                             16'h9404, 16'h0010};
   always #12.5 clk = ~clk;
   idc_idle_domain_control dut (.clk(clk), .rstn(rstn), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .idleCmd(idleCmd), .busError(busError), .domainIdle(domainIdle), .periphIdle(periphIdle),
      .dmaIdle(dmaIdle), .hostPortIdle(hostPortIdle), .sysClockStop(sysClockStop),
      .pllPowerDown(pllPowerDown));
   task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", name, exp, got);
         n_errors++;
      end
   endtask
   task wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1;
      @(posedge clk);
      regWrite <= 0;
   endtask
   // data stands only in the cycle after the strobe, so sample just past that edge
   task rd(input logic [15:0] a, input logic [15:0] exp);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1;
      @(posedge clk);
      regRead <= 0;
      #1 chk("regRdData", exp, regRdData);
   endtask
   task idle();
      @(posedge clk);
      idleCmd <= 1;
      @(posedge clk);
      idleCmd <= 0;
      #1;
   endtask
   task tally_and_finish();
      if (n_errors == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial
   begin
      #(25 * 5000);
      n_errors++;
      tally_and_finish();
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rstn <= 1;
      foreach (regs[i]) rd(regs[i], 16'h0000);
      wr(16'h0001, 16'hffff);
      rd(16'h0001, 16'h03ff);
      rd(16'h0002, 16'h0000);
      wr(16'h9400, 16'h00a5);
      wr(16'h9402, 16'h0003);
      wr(16'h9404, 16'h0001);
      rd(16'h9400, 16'h00a5);
      chk("domainIdle", 16'h0000, {6'h00, domainIdle});
      idle();
      chk("domainIdle", 16'h03ff, {6'h00, domainIdle});
      chk("flags", 16'h000f, {11'h0, flags});
      rd(16'h9404, 16'h0003);
      chk("periphIdle", 16'h00a5, periphIdle);
      rd(16'h0002, 16'h03ff);
      rd(16'h9401, 16'h00a5);
      rd(16'h9403, 16'h0003);
      foreach (badCfg[i])
      begin
         wr(16'h0001, {6'h00, badCfg[i]});
         idle();
         chk("refused", 16'h07ff, {5'h00, busError, domainIdle});
      end
      wr(16'h0001, 16'h0009);
      idle();
      chk("applied", 16'h0009, {5'h00, busError, domainIdle});
      chk("sysClockStop", 16'h0000, {15'h0, sysClockStop});
      wr(16'h9402, 16'h0001);
      rd(16'h9403, 16'h0001);
      wr(16'h0001, 16'h0002);
      idle();
      rd(16'h9403, 16'h0003);
      wr(16'h0001, 16'h0000);
      idle();
      chk("periphIdle", 16'h0000, periphIdle);
      tally_and_finish();
   end
endmodule // test_idle_domain_control
